// file: rtl/ebr_defs.svh
// Constants for the external bus controller: field codes, timing counts and reset values.
// Assumes inclusion by bare name from every file that needs them.
`ifndef EBR_DEFS_SVH
`define EBR_DEFS_SVH

`define EBR_SIZE_BYTE      2'h0
`define EBR_SIZE_WORD      2'h1
`define EBR_SIZE_LONG      2'h2
`define EBR_PORT_8         2'h0
`define EBR_PORT_16        2'h1
`define EBR_PORT_32        2'h2
`define EBR_IDLE_CODE_FOUR 2'h3
`define EBR_IDLE_FOUR      3'h4
`define EBR_REL_NEG_CYCLES 2'h2
`define EBR_REFRESH_CYCLES 3'h4
`define EBR_GAP_MAX        3'h7
`define EBR_ADDR_RESET     32'h0000_0000

`endif

// file: rtl/ebr_pkg.sv
// Types shared by the external bus controller and its master arbiter.
// Assumes nothing of its surroundings.
`default_nettype none
package ebr_pkg;

  typedef enum logic [2:0] {
    EBR_M_NONE = 3'h0,
    EBR_M_CPU  = 3'h1,
    EBR_M_DMA0 = 3'h2,
    EBR_M_DMA1 = 3'h3,
    EBR_M_ETX  = 3'h4,
    EBR_M_ERX  = 3'h5,
    EBR_M_REF  = 3'h6
  } ebr_master_t;

  typedef enum logic [3:0] {
    EBR_S_IDLE     = 4'h0,
    EBR_S_GAP      = 4'h1,
    EBR_S_SETUP    = 4'h2,
    EBR_S_WAIT     = 4'h3,
    EBR_S_STROBE   = 4'h4,
    EBR_S_REFRESH  = 4'h5,
    EBR_S_REL_NEG  = 4'h6,
    EBR_S_RELEASED = 4'h7,
    EBR_S_TAKE     = 4'h8
  } ebr_state_t;

endpackage
`default_nettype wire

// file: rtl/ebr_arb.sv
// Picks the next internal master of the external bus.
// Assumes requests come from logic on the same clock and that take pulses once per start.
`timescale 1ns/10ps
`default_nettype none
module ebr_arb
  import ebr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        cpu_req,
  input  wire logic [1:0]  dma_req,
  input  wire logic        edma_tx_req,
  input  wire logic        edma_rx_req,
  input  wire logic        refresh_req,
  input  wire logic        refresh_enable,
  input  wire logic        dma_priority_mode_bit,
  input  wire logic        lock,
  input  wire ebr_master_t lock_owner,
  input  wire logic        take,
  output ebr_master_t      pick
);

  logic etx_last_ff;
  logic dma_last_ff;
  logic nxt_etx_last;
  logic nxt_dma_last;

  always_comb begin
    pick = EBR_M_NONE;
    if (lock) begin
      pick = lock_owner;
    end else if (refresh_req && refresh_enable) begin
      pick = EBR_M_REF;
    end else if (edma_tx_req && edma_rx_req) begin
      pick = etx_last_ff ? EBR_M_ERX : EBR_M_ETX;
    end else if (edma_tx_req) begin
      pick = EBR_M_ETX;
    end else if (edma_rx_req) begin
      pick = EBR_M_ERX;
    end else if (dma_req == 2'h3) begin
      pick = (dma_priority_mode_bit && !dma_last_ff) ? EBR_M_DMA1 : EBR_M_DMA0;
    end else if (dma_req[0]) begin
      pick = EBR_M_DMA0;
    end else if (dma_req[1]) begin
      pick = EBR_M_DMA1;
    end else if (cpu_req) begin
      pick = EBR_M_CPU;
    end
  end

  always_comb begin
    nxt_etx_last = etx_last_ff;
    nxt_dma_last = dma_last_ff;
    if (take) begin
      case (pick)
        EBR_M_ETX: begin
          nxt_etx_last = 1'b1;
        end
        EBR_M_ERX: begin
          nxt_etx_last = 1'b0;
        end
        EBR_M_DMA0: begin
          nxt_dma_last = 1'b0;
        end
        EBR_M_DMA1: begin
          nxt_dma_last = 1'b1;
        end
        default: begin
          nxt_etx_last = etx_last_ff;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      etx_last_ff <= 1'b0;
      dma_last_ff <= 1'b1;
    end else begin
      etx_last_ff <= nxt_etx_last;
      dma_last_ff <= nxt_dma_last;
    end
  end

endmodule
`default_nettype wire

// file: rtl/ebr_bsc.sv
// External bus state controller: access sequencing, burst ROM, idle insertion and release.
// Assumes the granted master holds its request and acc_* steady until xfer_done.
//
// Contract
// - Burst ROM enable selects nibble mode space 0.
// - Nibble follow-on changes only address, chip select held.
// - Follow-on nibble access skips address setup.
// - Nibble only eligible reads on four-address ROM.
// - At most two accesses per nibble sequence.
// - Block transfers do four longword accesses.
// - Wait pin sampled only when waits configured.
// - Zero waits: follow-on nibble takes two cycles.
// - Idle considered after read then other space/write.
// - No idle write-write or same-space read-read.
// - Two-bit idle count per space, 0/1/2/4.
// - Empty cycles already present reduce idle count.
// - Write after read gets at least one idle.
// - Read after write needs no idle.
// - Handover empty cycle replaces idle cycles.
// - Release at once only when no cycle running.
// - CPU, DMA, Ethernet DMA, refresh are masters.
// - Ethernet channels alternate, one per period.
// - DMA channels fixed or round robin.
// - Control negated before release, driven negated first.
// - No release inside bursts or test-and-set pair.
// - No arbitration between partial cycles of access.
// - Internal bus work continues while bus released.
// - Low request gets low grant; high resumes.
// - Bus request sampled on falling edge.
// - Refresh pending output while bus released.
`timescale 1ns/10ps
`default_nettype none
`include "ebr_defs.svh"
module ebr_bsc
  import ebr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        cpu_req,
  input  wire logic [1:0]  dma_req,
  input  wire logic        edma_tx_req,
  input  wire logic        edma_rx_req,
  input  wire logic        refresh_req,
  input  wire logic        refresh_enable,
  input  wire logic        dma_priority_mode_bit,
  input  wire logic [31:0] acc_addr,
  input  wire logic [2:0]  acc_space,
  input  wire logic        acc_write,
  input  wire logic [1:0]  acc_size,
  input  wire logic        acc_burst16,
  input  wire logic        acc_lock,
  input  wire logic        burst_rom_enable,
  input  wire logic        rom_four_addr,
  input  wire logic [9:0]  port_width_cfg,
  input  wire logic [9:0]  wait_cfg,
  input  wire logic [7:0]  wait_control_reg_1,
  input  wire logic [1:0]  wait_control_reg_2,
  input  wire logic        wait_b,
  input  wire logic        bus_release_request_b,
  output logic             grant_cpu,
  output logic [1:0]       grant_dma,
  output logic             grant_edma_tx,
  output logic             grant_edma_rx,
  output logic             grant_refresh,
  output logic             beat_done,
  output logic             xfer_done,
  output logic             ext_bus_busy,
  output logic [31:0]      addr_out,
  output logic             addr_oe_b,
  output logic [4:0]       cs_n,
  output logic             rd_n,
  output logic             wr_n,
  output logic             data_oe_b,
  output logic             ctrl_oe_b,
  output logic             refresh_strobe,
  output logic             bus_grant_output_b,
  output logic             refresh_pending_request
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: first stage on the falling edge, change taken when
  // the second and third stages agree.

  logic [1:0] pin_raw;
  logic [1:0] pin_s1_ff;
  logic [1:0] pin_s2_ff;
  logic [1:0] pin_s3_ff;
  logic [1:0] pin_ff;
  logic       wait_low;
  logic       brq_low;

  assign pin_raw  = {bus_release_request_b, wait_b};
  assign wait_low = !pin_ff[0];
  assign brq_low  = !pin_ff[1];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
      always_ff @(negedge clk or negedge rst_b) begin
        if (!rst_b) begin
          pin_s1_ff[gi] <= 1'b1;
        end else begin
          pin_s1_ff[gi] <= pin_raw[gi];
        end
      end
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          pin_s2_ff[gi] <= 1'b1;
          pin_s3_ff[gi] <= 1'b1;
          pin_ff[gi]    <= 1'b1;
        end else begin
          pin_s2_ff[gi] <= pin_s1_ff[gi];
          pin_s3_ff[gi] <= pin_s2_ff[gi];
          pin_ff[gi]    <= (pin_s2_ff[gi] == pin_s3_ff[gi]) ? pin_s3_ff[gi] : pin_ff[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers.

  function automatic logic [1:0] cfg_of(input logic [9:0] cfg, input logic [2:0] space);
    logic [2:0] s;
    s = (space > 3'h4) ? 3'h4 : space;
    return cfg[{s, 1'b0} +: 2];
  endfunction

  function automatic logic [4:0] beats_of(input logic [1:0] size, input logic [1:0] port,
                                          input logic b16);
    logic [4:0] parts;
    parts = 5'h01;
    if (size == `EBR_SIZE_LONG) begin
      parts = (port == `EBR_PORT_8) ? 5'h04 : (port == `EBR_PORT_16) ? 5'h02 : 5'h01;
    end else if (size == `EBR_SIZE_WORD && port == `EBR_PORT_8) begin
      parts = 5'h02;
    end
    return b16 ? {parts[2:0], 2'b00} : parts;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Master selection.

  ebr_master_t pick;
  ebr_master_t owner_ff;
  logic        lock_ff;
  logic        take;

  ebr_arb u_arb (
    .clk                   (clk),
    .rst_b                 (rst_b),
    .cpu_req               (cpu_req),
    .dma_req               (dma_req),
    .edma_tx_req           (edma_tx_req),
    .edma_rx_req           (edma_rx_req),
    .refresh_req           (refresh_req),
    .refresh_enable        (refresh_enable),
    .dma_priority_mode_bit (dma_priority_mode_bit),
    .lock                  (lock_ff),
    .lock_owner            (owner_ff),
    .take                  (take),
    .pick                  (pick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer.

  ebr_state_t  st_ff;
  ebr_state_t  nxt_st;
  ebr_master_t nxt_owner;
  logic [31:0] addr_ff;
  logic [31:0] nxt_addr;
  logic [2:0]  space_ff;
  logic [2:0]  nxt_space;
  logic        write_ff;
  logic        nxt_write;
  logic [1:0]  port_ff;
  logic [1:0]  nxt_port;
  logic [1:0]  ws_ff;
  logic [1:0]  nxt_ws;
  logic        nib_ff;
  logic        nxt_nib;
  logic [4:0]  beat_ff;
  logic [4:0]  nxt_beat;
  logic [4:0]  beats_ff;
  logic [4:0]  nxt_beats;
  logic [2:0]  cnt_ff;
  logic [2:0]  nxt_cnt;
  logic [2:0]  gap_ff;
  logic [2:0]  nxt_gap;
  logic [2:0]  last_space_ff;
  logic [2:0]  nxt_last_space;
  logic        last_read_ff;
  logic        nxt_last_read;
  logic        handover_ff;
  logic        nxt_handover;
  logic        nxt_lock;
  logic        nxt_beat_done;
  logic        nxt_xfer_done;
  logic        beat_done_ff;
  logic        xfer_done_ff;
  logic [1:0]  new_port;
  logic [1:0]  idle_code;
  logic [2:0]  need;
  logic        new_nib;
  logic        wait_hold;

  assign new_port  = cfg_of(port_width_cfg, acc_space);
  assign idle_code = cfg_of({wait_control_reg_2, wait_control_reg_1}, last_space_ff);
  assign take      = (st_ff == EBR_S_IDLE) && (pick != EBR_M_NONE) && (pick != EBR_M_REF)
                     && !(brq_low && !lock_ff);
  assign wait_hold = (ws_ff != 2'h0) && wait_low;

  always_comb begin
    new_nib = burst_rom_enable && rom_four_addr && (acc_space == 3'h0) && !acc_write
              && (((new_port == `EBR_PORT_8) && (acc_size != `EBR_SIZE_BYTE))
                  || ((new_port == `EBR_PORT_16) && (acc_size == `EBR_SIZE_LONG)));
    need = (idle_code == `EBR_IDLE_CODE_FOUR) ? `EBR_IDLE_FOUR : {1'b0, idle_code};
    // Read then other space or write.
    if (!(last_read_ff && (acc_write || (acc_space != last_space_ff)))) begin
      need = 3'h0;
    end else if (acc_write && (need == 3'h0)) begin
      need = 3'h1;
    end
    need = (need > gap_ff) ? 3'(need - gap_ff) : 3'h0;
    if (handover_ff) begin
      need = 3'h0;
    end
  end

  always_comb begin
    nxt_st         = st_ff;
    nxt_owner      = owner_ff;
    nxt_addr       = addr_ff;
    nxt_space      = space_ff;
    nxt_write      = write_ff;
    nxt_port       = port_ff;
    nxt_ws         = ws_ff;
    nxt_nib        = nib_ff;
    nxt_beat       = beat_ff;
    nxt_beats      = beats_ff;
    nxt_cnt        = cnt_ff;
    nxt_gap        = gap_ff;
    nxt_last_space = last_space_ff;
    nxt_last_read  = last_read_ff;
    nxt_handover   = handover_ff;
    nxt_lock       = lock_ff;
    nxt_beat_done  = 1'b0;
    nxt_xfer_done  = 1'b0;
    case (st_ff)
      EBR_S_IDLE: begin
        if (pick == EBR_M_REF && !lock_ff) begin
          nxt_st       = EBR_S_REFRESH;
          nxt_owner    = EBR_M_REF;
          nxt_cnt      = 3'(`EBR_REFRESH_CYCLES - 3'h1);
          nxt_handover = 1'b0;
        end else if (brq_low && !lock_ff) begin
          nxt_st    = EBR_S_REL_NEG;
          nxt_owner = EBR_M_NONE;
          nxt_cnt   = {1'b0, `EBR_REL_NEG_CYCLES} - 3'h1;
        end else if (take) begin
          nxt_owner    = pick;
          nxt_addr     = acc_addr;
          nxt_space    = acc_space;
          nxt_write    = acc_write;
          nxt_port     = new_port;
          nxt_ws       = cfg_of(wait_cfg, acc_space);
          nxt_nib      = new_nib;
          nxt_beat     = 5'h00;
          nxt_beats    = beats_of(acc_size, new_port, acc_burst16);
          nxt_lock     = acc_lock && !acc_write;
          nxt_handover = 1'b0;
          nxt_gap      = 3'h0;
          nxt_cnt      = (need == 3'h0) ? 3'h0 : 3'(need - 3'h1);
          nxt_st       = (need == 3'h0) ? EBR_S_SETUP : EBR_S_GAP;
        end else if (gap_ff != `EBR_GAP_MAX) begin
          nxt_gap = 3'(gap_ff + 3'h1);
        end
      end
      // Idle insertion counts as a cycle.
      EBR_S_GAP: begin
        nxt_cnt = 3'(cnt_ff - 3'h1);
        if (cnt_ff == 3'h0) begin
          nxt_st = EBR_S_SETUP;
        end
      end
      EBR_S_SETUP: begin
        nxt_cnt = (ws_ff == 2'h0) ? 3'h0 : {1'b0, 2'(ws_ff - 2'h1)};
        nxt_st  = (ws_ff == 2'h0) ? EBR_S_STROBE : EBR_S_WAIT;
      end
      EBR_S_WAIT: begin
        if (cnt_ff != 3'h0) begin
          nxt_cnt = 3'(cnt_ff - 3'h1);
        end else if (!wait_hold) begin
          nxt_st = EBR_S_STROBE;
        end
      end
      EBR_S_STROBE: begin
        nxt_beat_done = 1'b1;
        nxt_beat      = 5'(beat_ff + 5'h01);
        nxt_addr      = addr_ff + ((port_ff == `EBR_PORT_8) ? 32'h0000_0001 :
                        (port_ff == `EBR_PORT_16) ? 32'h0000_0002 : 32'h0000_0004);
        if (nxt_beat == beats_ff) begin
          nxt_st         = EBR_S_IDLE;
          nxt_owner      = lock_ff ? owner_ff : EBR_M_NONE;
          nxt_xfer_done  = 1'b1;
          nxt_last_space = space_ff;
          nxt_last_read  = !write_ff;
          nxt_lock       = lock_ff && !write_ff;
        end else if (nib_ff && nxt_beat[0]) begin
          nxt_cnt = (ws_ff == 2'h0) ? 3'h0 : {1'b0, 2'(ws_ff - 2'h1)};
          nxt_st  = EBR_S_WAIT;
        end else begin
          nxt_st = EBR_S_SETUP;
        end
      end
      EBR_S_REFRESH: begin
        nxt_cnt = 3'(cnt_ff - 3'h1);
        if (cnt_ff == 3'h0) begin
          nxt_st        = EBR_S_IDLE;
          nxt_owner     = EBR_M_NONE;
          nxt_xfer_done = 1'b1;
          nxt_last_read = 1'b0;
        end
      end
      EBR_S_REL_NEG: begin
        nxt_cnt = 3'(cnt_ff - 3'h1);
        if (cnt_ff == 3'h0) begin
          nxt_st = EBR_S_RELEASED;
        end
      end
      EBR_S_RELEASED: begin
        if (!brq_low) begin
          nxt_st = EBR_S_TAKE;
        end
      end
      EBR_S_TAKE: begin
        nxt_st        = EBR_S_IDLE;
        nxt_handover  = 1'b1;
        nxt_gap       = 3'h0;
        nxt_last_read = 1'b0;
      end
      default: begin
        nxt_st = EBR_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff         <= EBR_S_IDLE;
      owner_ff      <= EBR_M_NONE;
      addr_ff       <= `EBR_ADDR_RESET;
      space_ff      <= 3'h0;
      write_ff      <= 1'b0;
      port_ff       <= `EBR_PORT_8;
      ws_ff         <= 2'h0;
      nib_ff        <= 1'b0;
      beat_ff       <= 5'h00;
      beats_ff      <= 5'h01;
      cnt_ff        <= 3'h0;
      gap_ff        <= 3'h0;
      last_space_ff <= 3'h0;
      last_read_ff  <= 1'b0;
      handover_ff   <= 1'b0;
      lock_ff       <= 1'b0;
      beat_done_ff  <= 1'b0;
      xfer_done_ff  <= 1'b0;
    end else begin
      st_ff         <= nxt_st;
      owner_ff      <= nxt_owner;
      addr_ff       <= nxt_addr;
      space_ff      <= nxt_space;
      write_ff      <= nxt_write;
      port_ff       <= nxt_port;
      ws_ff         <= nxt_ws;
      nib_ff        <= nxt_nib;
      beat_ff       <= nxt_beat;
      beats_ff      <= nxt_beats;
      cnt_ff        <= nxt_cnt;
      gap_ff        <= nxt_gap;
      last_space_ff <= nxt_last_space;
      last_read_ff  <= nxt_last_read;
      handover_ff   <= nxt_handover;
      lock_ff       <= nxt_lock;
      beat_done_ff  <= nxt_beat_done;
      xfer_done_ff  <= nxt_xfer_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin and status outputs, decoded from registered state; refresh_pending_request is also gated by refresh_req and refresh_enable.

  logic in_access;
  logic strobing;

  assign in_access = (st_ff == EBR_S_SETUP) || (st_ff == EBR_S_WAIT) || (st_ff == EBR_S_STROBE);
  assign strobing  = (st_ff == EBR_S_WAIT) || (st_ff == EBR_S_STROBE);

  assign addr_out  = addr_ff;
  assign cs_n      = in_access ? ~(5'h01 << space_ff) : 5'h1f;
  // Write data off before read strobe.
  assign rd_n      = !(strobing && !write_ff);
  assign wr_n      = !(strobing && write_ff);
  assign data_oe_b = !(strobing && write_ff);
  assign addr_oe_b = (st_ff == EBR_S_REL_NEG) || (st_ff == EBR_S_RELEASED);
  assign ctrl_oe_b = (st_ff == EBR_S_RELEASED);
  assign bus_grant_output_b = (st_ff != EBR_S_RELEASED);
  assign refresh_pending_request = (st_ff == EBR_S_RELEASED) && refresh_req && refresh_enable;
  assign refresh_strobe = (st_ff == EBR_S_REFRESH);
  assign ext_bus_busy   = (st_ff != EBR_S_IDLE);
  assign beat_done      = beat_done_ff;
  assign xfer_done      = xfer_done_ff;
  assign grant_cpu      = (owner_ff == EBR_M_CPU);
  assign grant_dma      = {owner_ff == EBR_M_DMA1, owner_ff == EBR_M_DMA0};
  assign grant_edma_tx  = (owner_ff == EBR_M_ETX);
  assign grant_edma_rx  = (owner_ff == EBR_M_ERX);
  assign grant_refresh  = (owner_ff == EBR_M_REF);

endmodule
`default_nettype wire

// file: testbench/ebr_bsc_checker.sv
// Concurrent checks on the pins, grants and release handshake of ebr_bsc.
// Assumes it is bound into ebr_bsc, which runs on one clock.
`timescale 1ns/10ps
`default_nettype none
module ebr_bsc_checker (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       refresh_req,
  input wire logic       refresh_enable,
  input wire logic       grant_cpu,
  input wire logic [1:0] grant_dma,
  input wire logic       grant_edma_tx,
  input wire logic       grant_edma_rx,
  input wire logic       grant_refresh,
  input wire logic       xfer_done,
  input wire logic       addr_oe_b,
  input wire logic [4:0] cs_n,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic       data_oe_b,
  input wire logic       ctrl_oe_b,
  input wire logic       refresh_strobe,
  input wire logic       bus_grant_output_b,
  input wire logic       refresh_pending_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////
  a_grant_released: assert property (!bus_grant_output_b |-> ctrl_oe_b && addr_oe_b)
    else $error("grant low while pins driven");
  a_neg_before_rel: assert property ($rose(ctrl_oe_b) |-> $past(cs_n, 2) == 5'h1f
    && $past(cs_n) == 5'h1f && $past(rd_n, 2) && $past(wr_n, 2))
    else $error("controls not negated before release");
  a_take_negated: assert property ($rose(bus_grant_output_b) |-> !ctrl_oe_b && !addr_oe_b
    && cs_n == 5'h1f && rd_n && wr_n)
    else $error("takeback not from negated level");
  a_refresh_pend: assert property ((!bus_grant_output_b && refresh_req && refresh_enable)[*2]
    |-> refresh_pending_request)
    else $error("refresh pending not shown");
  a_refresh_owner: assert property (refresh_strobe |-> grant_refresh)
    else $error("refresh without refresh owner");
  a_single_owner: assert property ($onehot0({grant_refresh, grant_edma_rx, grant_edma_tx, grant_dma, grant_cpu}))
    else $error("more than one owner");
  a_read_drive: assert property (!rd_n |-> data_oe_b && wr_n)
    else $error("data driven during read");
  a_strobe_cs: assert property ((!rd_n || !wr_n) |-> $onehot(~cs_n))
    else $error("strobe without one chip select");
  a_done_negated: assert property (xfer_done |-> cs_n == 5'h1f && rd_n && wr_n)
    else $error("cycle not ended at done");
endmodule
bind ebr_bsc ebr_bsc_checker ebr_bsc_checker_i (.clk, .rst_b, .refresh_req, .refresh_enable, .grant_cpu, .grant_dma,
  .grant_edma_tx, .grant_edma_rx, .grant_refresh, .xfer_done, .addr_oe_b, .cs_n, .rd_n, .wr_n, .data_oe_b,
  .ctrl_oe_b, .refresh_strobe, .bus_grant_output_b, .refresh_pending_request);
`default_nettype wire

// file: testbench/ebr_far_model.sv
// Far side: an external bus requester and a slow memory holding the wait pin.
// Assumes want and stall change on falling edges; both pins move on rising edges.
`timescale 1ns/10ps
`default_nettype none
module ebr_far_model (
  input  wire logic clk,
  input  wire logic want,
  input  wire logic stall,
  input  wire logic refresh_pending_request,
  output var logic  wait_b,
  output var logic  bus_release_request_b
);
  initial bus_release_request_b = 1'h1;
  initial wait_b = 1'h1;
  always @(posedge clk) bus_release_request_b <= !want || refresh_pending_request;
  always @(posedge clk) wait_b <= !stall;
endmodule
`default_nettype wire

// file: testbench/tb_ebr_bsc.sv
// Self-checking bench for ebr_bsc with a cycle model and a far-side model.
// Assumes package, design, checker and far-side model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_ebr_bsc;
  import ebr_pkg::*;
  logic        clk = 0, rst_b = 0, cpu_req = 0, edma_tx_req = 0, edma_rx_req = 0, want = 0, stall = 0;
  logic        refresh_req = 0, refresh_enable = 0, dma_priority_mode_bit = 0, acc_write = 0;
  logic        acc_burst16 = 0, burst_rom_enable = 0, rom_four_addr = 0, acc_lock = 0;
  logic [1:0]  dma_req = 0, acc_size = 0, wait_control_reg_2 = 0, grant_dma;
  logic [2:0]  acc_space = 0;
  logic [7:0]  wait_control_reg_1 = 0;
  logic [9:0]  port_width_cfg = 0, wait_cfg = 0;
  logic [31:0] acc_addr = 0, addr_out, seed = 32'h0000_4644;
  logic        grant_cpu, grant_edma_tx, grant_edma_rx, grant_refresh, beat_done, xfer_done, ext_bus_busy;
  logic        addr_oe_b, rd_n, wr_n, data_oe_b, ctrl_oe_b, refresh_strobe, bus_grant_output_b;
  logic        refresh_pending_request, wait_b, bus_release_request_b;
  logic [4:0]  cs_n;
  logic [5:0]  gv, g_last;
  logic [5:0]  q[$];
  int          err_count = 0, total_checks = 0, prev_sp = 0, prev_rd = 0;
  assign gv = {grant_refresh, grant_edma_rx, grant_edma_tx, grant_dma, grant_cpu};
  always #20 clk = ~clk;
  ebr_bsc ebr_bsc_i (.clk, .rst_b, .cpu_req, .dma_req, .edma_tx_req, .edma_rx_req, .refresh_req, .refresh_enable,
    .dma_priority_mode_bit, .acc_addr, .acc_space, .acc_write, .acc_size, .acc_burst16, .acc_lock,
    .burst_rom_enable, .rom_four_addr, .port_width_cfg, .wait_cfg, .wait_control_reg_1, .wait_control_reg_2,
    .wait_b, .bus_release_request_b, .grant_cpu, .grant_dma, .grant_edma_tx, .grant_edma_rx, .grant_refresh,
    .beat_done, .xfer_done, .ext_bus_busy, .addr_out, .addr_oe_b, .cs_n, .rd_n, .wr_n, .data_oe_b, .ctrl_oe_b,
    .refresh_strobe, .bus_grant_output_b, .refresh_pending_request);
  ebr_far_model ebr_far_model_i (.clk, .want, .stall, .refresh_pending_request, .wait_b, .bus_release_request_b);
  ////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
    end
  endtask
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One transfer by master m after e empty cycles, or 4 while stall is set; cycle count from the model.
  task automatic xfer(input int m, input int e);
    int n, x, w, p, g, pw, b;
    bit nib;
    logic [31:0] r;
    e = stall ? 4 : e;
    repeat (e) begin
      {edma_rx_req, edma_tx_req, dma_req, cpu_req} = '0;
      stall = 0;
      @(negedge clk);
    end
    r = rnd();
    for (int i = 0; i < 5; i++) port_width_cfg[2*i+:2] = 2'((r >> (2*i)) % 3);
    acc_addr = r & 32'hffff_fffc;
    r = rnd();
    {wait_control_reg_2, wait_control_reg_1, wait_cfg} = r[19:0];
    {dma_priority_mode_bit, rom_four_addr, burst_rom_enable, acc_write} = r[23:20];
    acc_size = 2'(r[25:24] % 3);
    acc_space = 3'(r[28:26] % 5);
    acc_burst16 = acc_size == 2 && r[29];
    w = wait_cfg[2*acc_space+:2];
    stall = w == 0 && r[30];
    pw = port_width_cfg[2*acc_space+:2];
    p = acc_size == 2 ? (pw == 0 ? 4 : pw == 1 ? 2 : 1) : (acc_size == 1 && pw == 0) ? 2 : 1;
    p = acc_burst16 ? 4 * p : p;
    nib = acc_space == 0 && burst_rom_enable && rom_four_addr && !acc_write
          && (pw == 0 ? acc_size != 0 : pw == 1 && acc_size == 2);
    x = 1;
    for (int i = 0; i < p; i++) x += (nib && i % 2) ? (w > 0 ? w : 1) + 1 : w + 2;
    if (prev_rd && (acc_write || acc_space != prev_sp)) begin
      g = prev_sp == 4 ? wait_control_reg_2 : wait_control_reg_1[2*prev_sp+:2];
      g = g == 3 ? 4 : (g == 0 && acc_write) ? 1 : g;
      x += g > e ? g - e : 0;
    end
    {edma_rx_req, edma_tx_req, dma_req, cpu_req} = 5'h1 << m;
    n = 0;
    b = 0;
    do begin
      @(negedge clk);
      n++;
      b += beat_done;
      if (n == x - 1) chk("owner busy", {1'h1, 6'h1 << m}, {ext_bus_busy, gv});
    end while (xfer_done !== 1'h1 && n < 400);
    chk("cycles", x, n);
    chk("beats", p, b);
    chk("address", acc_addr + p * (pw == 0 ? 1 : pw * 2), addr_out);
    prev_sp = acc_space;
    prev_rd = !acc_write;
  endtask
  ////////////////////
  initial begin
    repeat (8) @(negedge clk);
    chk("reset pins", 11'h7fc, {cs_n, rd_n, wr_n, data_oe_b, bus_grant_output_b, addr_oe_b, ctrl_oe_b});
    rst_b = 1;
    @(negedge clk);
    for (int k = 0; k < 80; k++) xfer(rnd() % 5, rnd() % 4);
    {edma_rx_req, edma_tx_req, dma_req, cpu_req} = '0;
    stall = 0;
    @(negedge clk);
    {refresh_enable, refresh_req, edma_rx_req, edma_tx_req, dma_req, cpu_req} = '1;
    {dma_priority_mode_bit, acc_write, acc_burst16} = '0;
    repeat (300) begin
      g_last = gv;
      @(negedge clk);
      if (gv != 0 && gv != g_last) q.push_back(gv);
      if (grant_refresh) refresh_req = 0;
      if (xfer_done) {edma_rx_req, edma_tx_req, dma_req, cpu_req} &= ~g_last[4:0];
    end
    chk("grant order", {6'h20, 6'h02, 6'h04, 6'h01}, {q[0], q[3], q[4], q[5]});
    chk("edma pair", 6'h18, q[1] | q[2]);
    want = 1;
    for (int i = 0; i < 20 && bus_grant_output_b; i++) @(negedge clk);
    chk("grant pin", 1'h0, bus_grant_output_b);
    cpu_req = 1;
    repeat (8) @(negedge clk);
    chk("cpu held off", 1'h0, grant_cpu);
    refresh_req = 1;
    for (int i = 0; i < 20 && !refresh_pending_request; i++) @(negedge clk);
    chk("refresh pending", 1'h1, refresh_pending_request);
    want = 0;
    for (int i = 0; i < 40 && !grant_refresh; i++) @(negedge clk);
    chk("refresh first", 1'h1, grant_refresh);
    refresh_req = 0;
    for (int i = 0; i < 40 && !grant_cpu; i++) @(negedge clk);
    chk("cpu resumes", 1'h1, grant_cpu);
    {acc_lock, wait_cfg} = {1'h1, 10'h3ff};
    for (int i = 0; i < 40 && !xfer_done; i++) @(negedge clk);
    want = 1;
    @(negedge clk);
    {acc_lock, acc_write} = 2'h1;
    for (int i = 0; i < 40 && !xfer_done; i++) @(negedge clk);
    @(negedge clk);
    chk("locked pair", 2'h3, {grant_cpu, bus_grant_output_b});
    conclude();
  end
  initial begin
    #(40 * 30000);
    err_count++;
    conclude();
  end
endmodule
`default_nettype wire
